// *** fsc_host_model.sv ***
// Serial host controller model driving the flash pins
`timescale 1ns/1ps

module fsc_host_model
(
  input  wire logic clk_i,
  input  wire logic so_i,
  output logic      cs_b_o,
  output logic      sclk_o,
  output logic      si_o
);
  // ********************
  // Frame driver
  // ********************
  // Idle pins: deselected, clock parked low
  initial
  begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    si_o   = 1'b0;
  end

  // Half serial period, well above the pin filter
  task automatic half;
    repeat (6) @(posedge clk_i);
  endtask : half

  // Send nb bits MSB first, then clock nr bits in from so
  task automatic xfer(input logic [39:0] d, input int nb, input int nr,
                      output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk_i);
    cs_b_o <= 1'b0;
    half();
    for (int i = 0; i < nb + nr; i++)
    begin
      si_o <= (i < nb) ? d[39 - i] : ~si_o;
      half();
      sclk_o <= 1'b1;
      if (i >= nb)
        rx = {rx[6:0], so_i};
      half();
      sclk_o <= 1'b0;
    end
    half();
    cs_b_o <= 1'b1;
    si_o   <= ~si_o;
    repeat (10) @(posedge clk_i);
  endtask : xfer

endmodule : fsc_host_model

// *** fsc_pkg.sv ***
// Package: opcodes, bit positions and timing of the flash status block
package fsc_pkg;

  // ************************************************************
  // Instruction codes
  // ************************************************************
  localparam logic [7:0] STATUS_READ_CMD     = 8'h05;
  localparam logic [7:0] CONFIG_READ_CMD     = 8'h15;
  localparam logic [7:0] WRITE_ENABLE_CMD    = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD   = 8'h04;
  localparam logic [7:0] STATUS_WRITE_CMD    = 8'h01;
  localparam logic [7:0] PAGE_PROGRAM_CMD    = 8'h02;
  localparam logic [7:0] SECTOR_ERASE_CMD    = 8'h20;
  localparam logic [7:0] HALF_BLOCK_ERASE_CMD = 8'h52;
  localparam logic [7:0] BLOCK_ERASE_CMD     = 8'hD8;
  localparam logic [7:0] CHIP_ERASE_CMD      = 8'h60;

  // ************************************************************
  // Bit counts along a frame (opcode bits included)
  // ************************************************************
  localparam logic [5:0] BITS_OPCODE  = 6'h08;
  localparam logic [5:0] BITS_SW_ONE  = 6'h10;
  localparam logic [5:0] BITS_SW_TWO  = 6'h18;
  localparam logic [5:0] BITS_ADDR    = 6'h20;
  localparam logic [5:0] BITS_PROGRAM = 6'h28;
  localparam logic [5:0] BITS_MAX     = 6'h3F;

  // ************************************************************
  // Register fields
  // ************************************************************
  localparam int CFG_ORIGIN_BIT = 3;
  localparam int CFG_DUMMY_BIT  = 6;
  localparam int ST_LOCK_BIT    = 7;
  localparam int ST_QUAD_BIT    = 6;
  localparam int ST_PROT_MSB    = 5;
  localparam int ST_PROT_LSB    = 2;
  localparam logic [3:0] PROT_RESET = 4'h0;

  // ************************************************************
  // Dummy cycle counts and pin indices
  // ************************************************************
  localparam logic [3:0] DUAL_DUMMY_LOW  = 4'h4;
  localparam logic [3:0] DUAL_DUMMY_HIGH = 4'h8;
  localparam logic [3:0] QUAD_DUMMY_LOW  = 4'h6;
  localparam logic [3:0] QUAD_DUMMY_HIGH = 4'hA;
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_WP = 3;
  localparam logic [3:0] PIN_RESET = 4'h9;
  localparam int CLK_PERIOD_NS = 5;

  typedef enum logic [1:0] {
    FSC_IDLE, FSC_OPCODE, FSC_COLLECT, FSC_STREAM
  } fsc_state_t;

endpackage : fsc_pkg

// *** fsc_regs.sv ***
// Status and configuration registers of a serial flash with protection
`timescale 1ns/1ps

module fsc_regs
#(
  parameter int STATUS_WRITE_NS = 5000000
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       cs_b_i,
  input  wire logic       sclk_i,
  input  wire logic       si_i,
  input  wire logic       wp_b_i,
  input  wire logic       target_protected_i,
  input  wire logic       op_done_i,
  output logic            so_o,
  output logic            so_oe_b_o,
  output logic            op_start_o,
  output logic [7:0]      op_code_o,
  output logic [23:0]     addr_o,
  output logic            busy_flag_o,
  output logic            write_latch_o,
  output logic [3:0]      protect_level_o,
  output logic            quad_io_enable_o,
  output logic            status_lock_o,
  output logic            hw_protect_state_o,
  output logic            protect_origin_select_o,
  output logic [3:0]      dual_dummy_o,
  output logic [3:0]      quad_dummy_o
);
  import fsc_pkg::*;

  localparam int SW_CYCLES =
    (STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TW = $clog2(SW_CYCLES + 1);

  initial
  begin
    if (SW_CYCLES < 1)
      $error("status write time must be at least one cycle");
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [3:0] pin_raw;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] lvl_q;

  assign pin_raw = {wp_b_i, si_i, sclk_i, cs_b_i};

  // Three stages per pin; a level counts once stages two and three agree
  for (genvar g = 0; g < 4; g++)
  begin : g_sync
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        s1_q[g]  <= PIN_RESET[g];
        s2_q[g]  <= PIN_RESET[g];
        s3_q[g]  <= PIN_RESET[g];
        lvl_q[g] <= PIN_RESET[g];
      end
      else
      begin
        s1_q[g] <= pin_raw[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g])
          lvl_q[g] <= s3_q[g];
      end
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic si_lvl;

  // Edge events from the filtered levels
  assign cs_fall   = !s2_q[PIN_CS] && !s3_q[PIN_CS] && lvl_q[PIN_CS];
  assign cs_rise   = s2_q[PIN_CS] && s3_q[PIN_CS] && !lvl_q[PIN_CS];
  assign sclk_rise = s2_q[PIN_SCLK] && s3_q[PIN_SCLK]
                     && !lvl_q[PIN_SCLK] && !lvl_q[PIN_CS];
  assign sclk_fall = !s2_q[PIN_SCLK] && !s3_q[PIN_SCLK]
                     && lvl_q[PIN_SCLK] && !lvl_q[PIN_CS];
  assign si_lvl    = lvl_q[PIN_SI];

  // ************************************************************
  // Register state
  // ************************************************************
  logic       busy_q;
  logic       wel_q;
  logic [3:0] prot_q;
  logic       quad_q;
  logic       lock_q;
  logic       origin_q;
  logic       dsel_q;
  logic       hwp;
  logic [7:0] status_byte;
  logic [7:0] config_byte;

  // Hardware protection: lock set, pin low, pin not reused for quad
  assign hwp = lock_q && !lvl_q[PIN_WP] && !quad_q;

  assign status_byte = {lock_q, quad_q, prot_q, wel_q, busy_q};
  assign config_byte = {1'b0, dsel_q, 2'b00, origin_q, 3'b000};

  // ************************************************************
  // Frame sequencer
  // ************************************************************
  fsc_state_t state_q;
  logic [5:0] cnt_q;
  logic [23:0] sh_q;
  logic [7:0] opc_q;
  logic [7:0] opc_now;
  logic       is_read;

  assign opc_now = {sh_q[6:0], si_lvl};
  assign is_read = (opc_now == STATUS_READ_CMD)
                   || (opc_now == CONFIG_READ_CMD);

  // Shifts opcode and payload, picks the frame's path
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= FSC_IDLE;
      cnt_q   <= '0;
      sh_q    <= '0;
      opc_q   <= '0;
    end
    else if (cs_fall)
    begin
      state_q <= FSC_OPCODE;
      cnt_q   <= '0;
    end
    else if (cs_rise)
      state_q <= FSC_IDLE;
    else if (sclk_rise)
    begin
      sh_q <= {sh_q[22:0], si_lvl};
      if (cnt_q != BITS_MAX)
        cnt_q <= cnt_q + 6'h01;
      unique case (state_q)
        FSC_OPCODE:
          if (cnt_q == BITS_OPCODE - 6'h01)
          begin
            opc_q <= opc_now;
            if (is_read)
              state_q <= FSC_STREAM;
            else if (busy_q)
              state_q <= FSC_IDLE;
            else
              state_q <= FSC_COLLECT;
          end
        FSC_COLLECT, FSC_STREAM, FSC_IDLE: ;
      endcase
    end
  end

  // ************************************************************
  // Execution at the end of a frame
  // ************************************************************
  logic at_end;
  logic is_pe;
  logic pe_len_ok;
  logic sw_len_ok;
  logic ex_write_enable_cmd;
  logic ex_wrdi;
  logic ex_sw;
  logic ex_pe;
  logic pe_allowed;
  logic sw_done;

  assign at_end  = cs_rise && (state_q == FSC_COLLECT);
  assign is_pe   = (opc_q == PAGE_PROGRAM_CMD)
                   || (opc_q == SECTOR_ERASE_CMD)
                   || (opc_q == HALF_BLOCK_ERASE_CMD)
                   || (opc_q == BLOCK_ERASE_CMD)
                   || (opc_q == CHIP_ERASE_CMD);
  assign pe_len_ok = (opc_q == PAGE_PROGRAM_CMD) ? (cnt_q >= BITS_PROGRAM)
                   : (opc_q == CHIP_ERASE_CMD) ? (cnt_q == BITS_OPCODE)
                   : (cnt_q == BITS_ADDR);
  assign sw_len_ok = (cnt_q == BITS_SW_ONE)
                     || (cnt_q == BITS_SW_TWO);
  assign ex_write_enable_cmd = at_end && (opc_q == WRITE_ENABLE_CMD)
                   && (cnt_q == BITS_OPCODE);
  assign ex_wrdi = at_end && (opc_q == WRITE_DISABLE_CMD)
                   && (cnt_q == BITS_OPCODE);
  assign ex_sw   = at_end && (opc_q == STATUS_WRITE_CMD) && sw_len_ok
                   && wel_q && !hwp;
  assign ex_pe   = at_end && is_pe && pe_len_ok && wel_q;
  assign pe_allowed = (opc_q == CHIP_ERASE_CMD) ? (prot_q == PROT_RESET)
                      : !target_protected_i;

  // Captures the target address once 24 address bits are in
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      addr_o <= '0;
    else if (sclk_rise && (state_q == FSC_COLLECT)
             && (cnt_q == BITS_ADDR - 6'h01))
      addr_o <= {sh_q[22:0], si_lvl};
  end

  // Hands an accepted program or erase to the array
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      op_start_o <= 1'b0;
      op_code_o  <= '0;
    end
    else
    begin
      op_start_o <= ex_pe && pe_allowed;
      if (ex_pe && pe_allowed)
        op_code_o <= opc_q;
    end
  end

  // ************************************************************
  // Self-timed status write cycle
  // ************************************************************
  logic [TW-1:0] tw_q;

  // Counts the status write time; end pulse closes the cycle
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tw_q <= '0;
    else if (ex_sw)
      tw_q <= TW'(SW_CYCLES);
    else if (tw_q != '0)
      tw_q <= tw_q - TW'(1);
  end

  assign sw_done = (tw_q == TW'(1));

  // ************************************************************
  // Volatile status bits
  // ************************************************************
  // Busy while a status write or array operation runs
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      busy_q <= 1'b0;
    else if (ex_sw || (ex_pe && pe_allowed))
      busy_q <= 1'b1;
    else if (sw_done || op_done_i)
      busy_q <= 1'b0;
  end

  // Write latch: set by write enable, cleared by write disable, completions or a refused program/erase
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      wel_q <= 1'b0;
    else if (ex_write_enable_cmd)
      wel_q <= 1'b1;
    else if (ex_wrdi || sw_done || (busy_q && op_done_i))
      wel_q <= 1'b0;
    else if (ex_pe && !pe_allowed)
      wel_q <= 1'b0;
  end

  // ************************************************************
  // Non-volatile and configuration bits
  // ************************************************************
  logic [7:0] sw_stat;
  logic [7:0] sw_cfg;

  assign sw_stat = (cnt_q == BITS_SW_TWO) ? sh_q[15:8] : sh_q[7:0];
  assign sw_cfg  = sh_q[7:0];

  // Status fields change only through an accepted status write
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      prot_q <= PROT_RESET;
      quad_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else if (ex_sw)
    begin
      prot_q <= sw_stat[ST_PROT_MSB:ST_PROT_LSB];
      quad_q <= sw_stat[ST_QUAD_BIT];
      lock_q <= sw_stat[ST_LOCK_BIT];
    end
  end

  // Second data byte: one-time origin select and dummy select
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      origin_q <= 1'b0;
      dsel_q   <= 1'b0;
    end
    else if (ex_sw && (cnt_q == BITS_SW_TWO))
    begin
      if (sw_cfg[CFG_ORIGIN_BIT])
        origin_q <= 1'b1;
      dsel_q <= sw_cfg[CFG_DUMMY_BIT];
    end
  end

  // ************************************************************
  // Serial answer
  // ************************************************************
  logic [2:0] idx_q;

  // Drives read bytes MSB first on falling serial clock, repeating
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      so_o      <= 1'b0;
      so_oe_b_o <= 1'b1;
      idx_q     <= 3'h7;
    end
    else
    begin
      so_oe_b_o <= !((state_q == FSC_STREAM) && !cs_rise);
      if (state_q != FSC_STREAM)
        idx_q <= 3'h7;
      else if (sclk_fall)
      begin
        so_o  <= (opc_q == STATUS_READ_CMD) ? status_byte[idx_q]
                 : config_byte[idx_q];
        idx_q <= idx_q - 3'h1;
      end
    end
  end

  // ************************************************************
  // Registered views for the array and read paths
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      busy_flag_o             <= 1'b0;
      write_latch_o           <= 1'b0;
      protect_level_o         <= PROT_RESET;
      quad_io_enable_o        <= 1'b0;
      status_lock_o           <= 1'b0;
      hw_protect_state_o      <= 1'b0;
      protect_origin_select_o <= 1'b0;
      dual_dummy_o            <= DUAL_DUMMY_LOW;
      quad_dummy_o            <= QUAD_DUMMY_LOW;
    end
    else
    begin
      busy_flag_o             <= busy_q;
      write_latch_o           <= wel_q;
      protect_level_o         <= prot_q;
      quad_io_enable_o        <= quad_q;
      status_lock_o           <= lock_q;
      hw_protect_state_o      <= hwp;
      protect_origin_select_o <= origin_q;
      dual_dummy_o <= dsel_q ? DUAL_DUMMY_HIGH : DUAL_DUMMY_LOW;
      quad_dummy_o <= dsel_q ? QUAD_DUMMY_HIGH : QUAD_DUMMY_LOW;
    end
  end

endmodule : fsc_regs

// *** fsc_regs_monitor.sv ***
// Checker of the flash status block port behaviour
`timescale 1ns/1ps

module fsc_regs_monitor
(
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic       cs_b_i,
  input wire logic       wp_b_i,
  input wire logic       op_done_i,
  input wire logic       so_oe_b_o,
  input wire logic       op_start_o,
  input wire logic       busy_flag_o,
  input wire logic       write_latch_o,
  input wire logic [3:0] protect_level_o,
  input wire logic       quad_io_enable_o,
  input wire logic       status_lock_o,
  input wire logic       hw_protect_state_o,
  input wire logic       protect_origin_select_o,
  input wire logic [3:0] dual_dummy_o,
  input wire logic [3:0] quad_dummy_o
);
  // ********************
  // Port relations
  // ********************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_dummy;
    (dual_dummy_o == 4'h4 && quad_dummy_o == 4'h6) ||
    (dual_dummy_o == 4'h8 && quad_dummy_o == 4'hA);
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("dummy counts not a legal pair");

  property p_hwp;
    $stable(wp_b_i) [*8] |-> hw_protect_state_o ==
      (status_lock_o & ~quad_io_enable_o & ~wp_b_i);
  endproperty
  a_hwp: assert property (p_hwp)
    else $error("hardware protection state wrong");

  property p_origin;
    !$fell(protect_origin_select_o);
  endproperty
  a_origin: assert property (p_origin)
    else $error("origin select went back to zero");

  property p_start;
    op_start_o |-> write_latch_o ##1 busy_flag_o;
  endproperty
  a_start: assert property (p_start)
    else $error("operation start without latch or busy");

  property p_done;
    busy_flag_o && op_done_i |-> ##2 !busy_flag_o && !write_latch_o;
  endproperty
  a_done: assert property (p_done)
    else $error("busy or latch kept after completion");

  property p_oe;
    cs_b_i [*6] |-> so_oe_b_o;
  endproperty
  a_oe: assert property (p_oe)
    else $error("serial output driven while deselected");

  property p_prot;
    $changed({status_lock_o, protect_level_o}) |->
      cs_b_i && !$past(hw_protect_state_o);
  endproperty
  a_prot: assert property (p_prot)
    else $error("lock or level changed illegally");

  property p_latch;
    $rose(write_latch_o) |-> cs_b_i;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch set inside a frame");

endmodule : fsc_regs_monitor

bind fsc_regs fsc_regs_monitor u_mon (.clk_i, .rst_b_i, .cs_b_i, .wp_b_i,
  .op_done_i, .so_oe_b_o, .op_start_o, .busy_flag_o, .write_latch_o,
  .protect_level_o, .quad_io_enable_o, .status_lock_o, .hw_protect_state_o,
  .protect_origin_select_o, .dual_dummy_o, .quad_dummy_o);

// *** test_flash_status_config_regs.sv ***
// Self-checking bench of the flash status block
`timescale 1ns/1ps

module test_flash_status_config_regs;
  import fsc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wp_b = 1'b1;
  logic        tgt = 1'b0;
  logic        done = 1'b0;
  logic        cs_b, sclk, si, so, hwp;
  logic [3:0]  dual, quad;
  logic [23:0] addr, a;
  logic [7:0]  v, sw, cf, opc;
  logic        dc, org;
  int          seed = 47339;
  int          n_fail = 0;
  int          n_checks = 0;
  int          starts = 0;

  fsc_regs #(.STATUS_WRITE_NS(3000)) dut (.clk_i(clk), .rst_b_i(rst_b),
    .cs_b_i(cs_b), .sclk_i(sclk), .si_i(si), .wp_b_i(wp_b),
    .target_protected_i(tgt), .op_done_i(done), .so_o(so),
    .so_oe_b_o(), .op_start_o(), .op_code_o(opc), .addr_o(addr),
    .busy_flag_o(), .write_latch_o(), .protect_level_o(),
    .quad_io_enable_o(), .status_lock_o(), .hw_protect_state_o(hwp),
    .protect_origin_select_o(), .dual_dummy_o(dual), .quad_dummy_o(quad));

  fsc_host_model host (.clk_i(clk), .so_i(so), .cs_b_o(cs_b),
    .sclk_o(sclk), .si_o(si));

  // Clock and accepted operation count
  always #2.5 clk = ~clk;
  always @(posedge clk)
    if (dut.op_start_o === 1'b1)
      starts++;

  // Expected dummy pair for a select value
  function automatic logic [7:0] dum_exp(input logic s);
    return s ? {DUAL_DUMMY_HIGH, QUAD_DUMMY_HIGH}
             : {DUAL_DUMMY_LOW, QUAD_DUMMY_LOW};
  endfunction : dum_exp

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cmd(input logic [39:0] d, input int nb);
    logic [7:0] x;
    host.xfer(d, nb, 0, x);
  endtask : cmd

  task automatic rd(output logic [7:0] r);
    host.xfer({STATUS_READ_CMD, 32'h0}, 8, 8, r);
  endtask : rd

  // Read status until idle, bounded
  task automatic poll(output logic [7:0] r);
    for (int k = 0; k < 12; k++)
    begin
      rd(r);
      if (r[0] === 1'b0)
        break;
    end
  endtask : poll

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // Watchdog against a hung handshake
  initial
  begin
    #(60000 * CLK_PERIOD_NS);
    n_fail++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    org = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd(v);
    chk("status", 8'h00, v);
    host.xfer({CONFIG_READ_CMD, 32'h0}, 8, 8, v);
    chk("config", 8'h00, v & 8'h48);
    chk("dummy", dum_exp(1'b0), {dual, quad});
    cmd({PAGE_PROGRAM_CMD, 32'h0}, 40);
    chk("starts", 8'h00, 8'(starts));
    cmd({WRITE_ENABLE_CMD, 32'h0}, 8);
    rd(v);
    chk("status", 8'h02, v);
    a = 24'($random(seed));
    cmd({PAGE_PROGRAM_CMD, a, 8'h5A}, 40);
    chk("starts", 8'h01, 8'(starts));
    chk("addr", a[7:0], addr[7:0]);
    chk("op_code", PAGE_PROGRAM_CMD, opc);
    rd(v);
    chk("status", 8'h03, v);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    poll(v);
    chk("status", 8'h00, v);
    for (int k = 0; k < 3; k++)
    begin
      sw = (8'($random(seed)) & 8'h3C) | 8'h04;
      cf = 8'($random(seed));
      dc = cf[6];
      org = org | cf[3];
      cmd({WRITE_ENABLE_CMD, 32'h0}, 8);
      cmd({STATUS_WRITE_CMD, sw, cf, 16'h0}, 24);
      rd(v);
      chk("status", sw | 8'h03, v);
      poll(v);
      chk("status", sw, v);
      host.xfer({CONFIG_READ_CMD, 32'h0}, 8, 8, v);
      chk("config", {1'b0, dc, 2'h0, org, 3'h0}, v & 8'h48);
      chk("dummy", dum_exp(dc), {dual, quad});
    end
    cmd({WRITE_ENABLE_CMD, 32'h0}, 8);
    cmd({STATUS_WRITE_CMD, 8'h00, 24'h0}, 20);
    rd(v);
    chk("status", sw | 8'h02, v);
    cmd({CHIP_ERASE_CMD, 32'h0}, 8);
    rd(v);
    chk("status", sw, v);
    cmd({WRITE_ENABLE_CMD, 32'h0}, 8);
    tgt <= 1'b1;
    cmd({SECTOR_ERASE_CMD, a, 8'h00}, 32);
    tgt <= 1'b0;
    rd(v);
    chk("status", sw, v);
    chk("starts", 8'h01, 8'(starts));
    cmd({WRITE_ENABLE_CMD, 32'h0}, 8);
    cmd({STATUS_WRITE_CMD, 8'h80, 24'h0}, 16);
    poll(v);
    chk("status", 8'h80, v);
    wp_b <= 1'b0;
    repeat (10) @(posedge clk);
    chk("hw_protect", 8'h01, {7'h0, hwp});
    cmd({WRITE_ENABLE_CMD, 32'h0}, 8);
    cmd({STATUS_WRITE_CMD, 8'h00, 24'h0}, 16);
    rd(v);
    chk("status", 8'h82, v);
    wp_b <= 1'b1;
    repeat (10) @(posedge clk);
    cmd({STATUS_WRITE_CMD, 8'hC0, 24'h0}, 16);
    poll(v);
    chk("status", 8'hC0, v);
    wp_b <= 1'b0;
    repeat (10) @(posedge clk);
    chk("hw_protect", 8'h00, {7'h0, hwp});
    complete_run();
  end

endmodule : test_flash_status_config_regs
